/* File: tebf_pkg.sv */
// Package of constants and carrier types for the trigger event block formatter.
// What this block does
// - Blocks hold programmed trigger count, ordered sections.
// - Header one: 10000, slot, board type.
// - Header one: block number low bits, size.
// - Header two: pattern, timestamp flag, 0x20, size.
// - Trailer: 10001, slot, sync event flag.
// - Trailer counts event words only.
// - Empty buffer read returns marker word.
// - D64 filler carries slot and block number.
// - 2eSST filler carries slot and fixed pattern.
// - Event header top byte is trigger type.
// - Physics types split processor and panel bits.
// - Multi, software, random types; master mode inputs.
// - Event header: 0x01, event word count.
// - Second word: trigger number starting at one.
// - Format bit one adds timing word.
// - Format bit two adds 48-bit extension word.
// - Alternate variant repacks the extension word.
// - Format bit three adds input pattern word.
package tebf_pkg;
   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0] TEBF_OFS_CTRL = 8'h00;
   localparam logic [7:0] TEBF_OFS_STATUS = 8'h04;
   localparam logic [7:0] TEBF_OFS_BLKSIZE = 8'h14;
   localparam logic [7:0] TEBF_OFS_FORMAT = 8'h18;
   localparam logic [7:0] TEBF_OFS_DATA = 8'h20;
   localparam logic [7:0] TEBF_OFS_BLKNUM = 8'h24;
   // Format register bit positions.
   localparam int TEBF_FMT_TIMING = 1;
   localparam int TEBF_FMT_EXT = 2;
   localparam int TEBF_FMT_PATTERN = 3;
   // Control register bit positions.
   localparam int TEBF_CTL_SST = 0;
   localparam int TEBF_CTL_MASTER = 1;
   localparam int TEBF_CTL_ALT = 2;
   localparam int TEBF_CTL_TSTAMP = 3;
   // Reset values.
   localparam logic [7:0] TEBF_BLKSIZE_RST = 8'h01;
   localparam logic [3:0] TEBF_FORMAT_RST = 4'h0;
   localparam logic [3:0] TEBF_CTRL_RST = 4'h0;
   // Board type code; the value is arbitrary.
   localparam logic [3:0] TEBF_BOARD_TYPE = 4'h5;
   // Word indicators and fixed patterns.
   localparam logic [4:0] TEBF_IND_BHDR = 5'h10;
   localparam logic [4:0] TEBF_IND_BTRL = 5'h11;
   localparam logic [4:0] TEBF_IND_EMPTY = 5'h1e;
   localparam logic [4:0] TEBF_IND_FILL = 5'h1f;
   localparam logic [14:0] TEBF_HDR2_PAT = 15'h7f88;
   localparam logic [7:0] TEBF_HDR2_CONST = 8'h20;
   localparam logic [21:0] TEBF_EMPTY_PAT = 22'h00bad0;
   localparam logic [21:0] TEBF_SST_PAT = 22'h0f1110;
   localparam logic [7:0] TEBF_EVT_CONST = 8'h01;
   localparam logic [15:0] TEBF_PAT_MARK = 16'hda56;
   // Trigger type codes.
   localparam logic [7:0] TEBF_TT_FILLER = 8'h00;
   localparam logic [7:0] TEBF_TT_PANEL_BASE = 8'h20;
   localparam logic [7:0] TEBF_TT_MULTI = 8'hfc;
   localparam logic [7:0] TEBF_TT_SOFT = 8'hfd;
   localparam logic [7:0] TEBF_TT_RANDOM = 8'hfe;
   // Trigger timing step in ns and clock period in ns.
   localparam int TEBF_TIME_STEP_NS = 4;
   localparam int TEBF_CLK_NS = 10;

   // Source of a trigger, as reported alongside it.
   typedef enum logic [2:0] {
      TEBF_SRC_GTP = 3'h0,
      TEBF_SRC_PANEL = 3'h1,
      TEBF_SRC_MULTI = 3'h2,
      TEBF_SRC_SOFT = 3'h3,
      TEBF_SRC_RANDOM = 3'h4,
      TEBF_SRC_FILLER = 3'h5
   } tebf_src_t;

   // One trigger as captured from the trigger logic.
   typedef struct packed {
      tebf_src_t src;
      logic [4:0] bit_idx;
      logic [5:0] panel_in;
      logic [3:0] dup_bus;
      logic [7:0] local_cnt;
      logic [47:0] tstamp;
   } tebf_trig_t;

   // Outbound readout word group.
   typedef struct packed {
      logic [31:0] data;
      logic empty;
   } tebf_word_t;
endpackage

/* File: tebf_formatter.sv */
// Trigger event block formatter with Wishbone register and readout port.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
module tebf_formatter (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [4:0] slot_geographic_id,
   input wire logic sync_event_flag,
   input wire logic trig_valid,
   output logic trig_ready,
   input wire tebf_pkg::tebf_trig_t trig_in,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import tebf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Types and declarations.

   // Sequencer states, one-hot.
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_HDR1 = 8'h02,
      ST_HDR2 = 8'h04,
      ST_EVT = 8'h08,
      ST_WAIT = 8'h10,
      ST_TRL = 8'h20,
      ST_FILL = 8'h40,
      ST_DONE = 8'h80
   } tebf_state_t;

   tebf_state_t state_r; // Position inside the current block.
   logic [3:0] ctrl_r; // Transfer mode, master, variant and timestamp bits.
   logic [7:0] blksize_r; // Triggers per block.
   logic [3:0] format_r; // Optional word enables.
   logic [21:0] blknum_r; // Block number, counts from one.
   logic [47:0] trignum_r; // Trigger number of the current event.
   logic [7:0] evt_in_blk_r; // Events already placed in this block.
   logic [2:0] word_idx_r; // Word index inside the current event.
   logic [20:0] wcount_r; // Event words placed in this block.
   logic [1:0] fill_left_r; // Filler words still owed.
   tebf_trig_t trig_r; // Trigger being formatted.
   logic [31:0] word_r; // Word presented on the data register.
   logic word_empty_r; // High when no formatted word is waiting.
   logic ack_r; // Bus acknowledge.
   logic [31:0] rdat_r; // Registered bus read data.
   logic bus_req; // A new bus request this cycle.
   logic data_pop; // The reader takes the presented word.
   logic [2:0] evt_words; // Words in one event beyond its header.
   logic [2:0] last_idx; // Index of the last word of an event.
   logic [7:0] trig_type; // Encoded trigger type.
   logic [31:0] evt_word; // Word of the event at word_idx_r.
   logic [1:0] fill_need; // Fillers to append after the trailer.

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave.

   // One request is taken on its first cycle; ack drops the cycle after.
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign data_pop = bus_req & ~wb_we_i & (wb_adr_i == TEBF_OFS_DATA);
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // Acknowledge every request, mapped or not, one cycle after it arrives.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req;
      end
   end

   // Read data mux; unmapped offsets read zero.
   // The data read is the only read with a side effect: it pops the word.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdat_r <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            TEBF_OFS_CTRL: rdat_r <= {28'h0000000, ctrl_r};
            TEBF_OFS_STATUS: rdat_r <= {24'h000000, state_r};
            TEBF_OFS_BLKSIZE: rdat_r <= {24'h000000, blksize_r};
            TEBF_OFS_FORMAT: rdat_r <= {28'h0000000, format_r};
            TEBF_OFS_BLKNUM: rdat_r <= {10'h000, blknum_r};
            TEBF_OFS_DATA: begin
               // An empty buffer answers with the marker word.
               if (word_empty_r) begin
                  rdat_r <= {TEBF_IND_EMPTY, slot_geographic_id, TEBF_EMPTY_PAT};
               end else begin
                  rdat_r <= word_r;
               end
            end
            default: rdat_r <= 32'h0000_0000;
         endcase
      end
   end

   // Writable registers; only the low byte lane carries these fields.
   // Writes during a block take effect at once; software must change size and
   // format only between blocks, or the header and the closing count disagree.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_r <= TEBF_CTRL_RST;
         blksize_r <= TEBF_BLKSIZE_RST;
         format_r <= TEBF_FORMAT_RST;
      end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            TEBF_OFS_CTRL: ctrl_r <= wb_dat_i[3:0];
            // A zero size would close a block only after 256 triggers, so it is held at one.
            TEBF_OFS_BLKSIZE: blksize_r <= (wb_dat_i[7:0] == 8'h00) ? 8'h01 : wb_dat_i[7:0];
            TEBF_OFS_FORMAT: format_r <= {wb_dat_i[3:1], 1'b0};
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event word assembly.

   // Enabled optional words only, so the header count matches them.
   assign evt_words = 3'd1 + {2'b00, format_r[TEBF_FMT_TIMING]}
      + {2'b00, format_r[TEBF_FMT_EXT]} + {2'b00, format_r[TEBF_FMT_PATTERN]};
   assign last_idx = evt_words;

   // Trigger type code from the source of the trigger.
   always_comb begin
      case (trig_r.src)
         TEBF_SRC_GTP: trig_type = {3'b000, trig_r.bit_idx} + 8'h01;
         TEBF_SRC_PANEL: trig_type = TEBF_TT_PANEL_BASE + {3'b000, trig_r.bit_idx} + 8'h01;
         TEBF_SRC_MULTI: trig_type = TEBF_TT_MULTI;
         TEBF_SRC_SOFT: trig_type = TEBF_TT_SOFT;
         TEBF_SRC_RANDOM: trig_type = TEBF_TT_RANDOM;
         default: trig_type = TEBF_TT_FILLER;
      endcase
      // In master mode the top six bits carry the supervisor inputs.
      if (ctrl_r[TEBF_CTL_MASTER]) begin
         trig_type = {trig_r.panel_in, trig_type[1:0]};
      end
   end

   // Word chosen by slot index; disabled optional words are skipped.
   always_comb begin
      evt_word = 32'h0000_0000;
      case (word_idx_r)
         3'd0: evt_word = {trig_type, TEBF_EVT_CONST, 13'h0000, evt_words};
         3'd1: evt_word = trignum_r[31:0];
         default: begin
            // Later slots walk the enabled options in ascending order.
            if (format_r[TEBF_FMT_TIMING] && word_idx_r == 3'd2) begin
               evt_word = trig_r.tstamp[31:0];
            end else if (format_r[TEBF_FMT_EXT] && word_idx_r ==
                         3'd2 + {2'b00, format_r[TEBF_FMT_TIMING]}) begin
               if (ctrl_r[TEBF_CTL_ALT]) begin
                  evt_word = {trig_r.dup_bus, trig_r.local_cnt, trignum_r[35:32],
                              trig_r.tstamp[47:32]};
               end else begin
                  evt_word = {trignum_r[47:32], trig_r.tstamp[47:32]};
               end
            end else begin
               evt_word = {TEBF_PAT_MARK, 10'h000, trig_r.panel_in};
            end
         end
      endcase
   end

   // Fillers for even counts: headers, events and trailer together.
   // Both transfer modes need exactly one filler to reach an even total; two
   // fillers would leave the total odd. The mode only picks the filler's type.
   always_comb begin
      fill_need = 2'd0;
      if (wcount_r[0] == 1'b0) begin
         // Two headers plus trailer make the total odd.
         fill_need = 2'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block sequencer.

   // Ready is combinational so a trigger offered in IDLE is taken at once; while
   // the words of an event are still being loaded the source has to wait.
   assign trig_ready = (state_r == ST_WAIT) | (state_r == ST_IDLE);

   // The word register holds one word ahead of the reader, so a pop and the
   // loading of the next word fall in the same cycle without a bubble.
   // HDR1, HDR2, EVT, TRL and FILL each load one word at a time, then wait for the reader to take it.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         word_r <= 32'h0000_0000;
         word_empty_r <= 1'b1;
         blknum_r <= 22'h000001;
         trignum_r <= 48'h0000_0000_0001;
         evt_in_blk_r <= 8'h00;
         word_idx_r <= 3'd0;
         wcount_r <= 21'h000000;
         fill_left_r <= 2'd0;
         trig_r <= '0;
      end else begin
         if (data_pop) begin
            word_empty_r <= 1'b1;
         end
         case (state_r)
            ST_IDLE: begin
               // The first trigger opens a new block.
               if (trig_valid) begin
                  trig_r <= trig_in;
                  state_r <= ST_HDR1;
               end
            end
            ST_HDR1: begin
               if (word_empty_r || data_pop) begin
                  word_r <= {TEBF_IND_BHDR, slot_geographic_id, TEBF_BOARD_TYPE,
                             blknum_r[9:0], blksize_r};
                  word_empty_r <= 1'b0;
                  state_r <= ST_HDR2;
               end
            end
            ST_HDR2: begin
               if (word_empty_r || data_pop) begin
                  word_r <= {TEBF_HDR2_PAT, ctrl_r[TEBF_CTL_TSTAMP], TEBF_HDR2_CONST,
                             blksize_r};
                  word_empty_r <= 1'b0;
                  word_idx_r <= 3'd0;
                  state_r <= ST_EVT;
               end
            end
            ST_EVT: begin
               if (word_empty_r || data_pop) begin
                  word_r <= evt_word;
                  word_empty_r <= 1'b0;
                  wcount_r <= wcount_r + 21'd1;
                  if (word_idx_r == last_idx) begin
                     word_idx_r <= 3'd0;
                     trignum_r <= trignum_r + 48'd1;
                     evt_in_blk_r <= evt_in_blk_r + 8'd1;
                     state_r <= (evt_in_blk_r + 8'd1 == blksize_r) ? ST_TRL : ST_WAIT;
                  end else begin
                     word_idx_r <= word_idx_r + 3'd1;
                  end
               end
            end
            ST_WAIT: begin
               // Next trigger of the same block.
               if (trig_valid) begin
                  trig_r <= trig_in;
                  state_r <= ST_EVT;
               end
            end
            ST_TRL: begin
               if (word_empty_r || data_pop) begin
                  word_r <= {TEBF_IND_BTRL, slot_geographic_id, sync_event_flag,
                             wcount_r};
                  word_empty_r <= 1'b0;
                  fill_left_r <= fill_need;
                  state_r <= (fill_need == 2'd0) ? ST_DONE : ST_FILL;
               end
            end
            ST_FILL: begin
               if (word_empty_r || data_pop) begin
                  if (ctrl_r[TEBF_CTL_SST]) begin
                     word_r <= {TEBF_IND_FILL, slot_geographic_id, TEBF_SST_PAT};
                  end else begin
                     word_r <= {TEBF_IND_FILL, slot_geographic_id, blknum_r};
                  end
                  word_empty_r <= 1'b0;
                  fill_left_r <= fill_left_r - 2'd1;
                  if (fill_left_r == 2'd1) begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               // Close the block and prepare the next one.
               blknum_r <= blknum_r + 22'd1;
               evt_in_blk_r <= 8'h00;
               wcount_r <= 21'h000000;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   // Apart from the ack, empty-marker, block-size and filler-even checks, assertions watch the word register, which is what the reader sees next.
   ack_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
   empty_marker_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (data_pop && word_empty_r) |=> (wb_dat_o[31:22] == {TEBF_IND_EMPTY, slot_geographic_id}))
      else $error("empty read did not return marker");
   header_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == ST_HDR2) |-> (word_r[31:27] == TEBF_IND_BHDR && word_r[7:0] == blksize_r))
      else $error("first block header malformed");
   header_two_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == ST_EVT && $past(state_r) == ST_HDR2) |-> (word_r[15:8] == TEBF_HDR2_CONST))
      else $error("second block header malformed");
   trailer_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ($past(state_r) == ST_TRL && state_r != ST_TRL)
      |-> (word_r[31:27] == TEBF_IND_BTRL && word_r[20:0] == wcount_r))
      else $error("trailer word count wrong");
   block_size_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == ST_TRL) |-> (evt_in_blk_r == blksize_r))
      else $error("block closed with wrong event count");
   filler_even_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == ST_DONE) |-> (wcount_r[0] == 1'b1 || $past(state_r) == ST_FILL))
      else $error("odd block length without filler");
   pattern_word_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (word_r[31:16] == TEBF_PAT_MARK && state_r == ST_WAIT) |-> (word_r[15:6] == 10'h000))
      else $error("pattern word reserved bits set");
   trig_num_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == ST_EVT && word_idx_r == 3'd1 && (word_empty_r || data_pop))
      |=> (word_r == $past(trignum_r[31:0]))) else $error("trigger number word wrong");
   block_number_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == ST_HDR2) |-> (word_r[17:8] == blknum_r[9:0]))
      else $error("block number field wrong");
   event_header_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == ST_EVT && word_idx_r == 3'd0 && (word_empty_r || data_pop))
      |=> (word_r[23:16] == TEBF_EVT_CONST && word_r[15:3] == 13'h0000))
      else $error("event header constant wrong");
   sst_filler_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == ST_FILL && ctrl_r[TEBF_CTL_SST] && (word_empty_r || data_pop))
      |=> (word_r[31:27] == TEBF_IND_FILL && word_r[21:0] == TEBF_SST_PAT))
      else $error("2eSST filler word wrong");

   // Covers show that each main scenario is reached.
   block_done_c: cover property (@(posedge clk_sys) state_r == ST_DONE);
   fill_used_c: cover property (@(posedge clk_sys) state_r == ST_FILL);
   empty_read_c: cover property (@(posedge clk_sys) data_pop && word_empty_r);
   sst_fill_c: cover property (@(posedge clk_sys) state_r == ST_FILL && ctrl_r[TEBF_CTL_SST]);
   master_event_c: cover property (@(posedge clk_sys)
      state_r == ST_EVT && ctrl_r[TEBF_CTL_MASTER]);
endmodule

/* File: tebf_wb_reader.sv */
// Readout controller model: a classic Wishbone master that fetches words.
`timescale 1ns/100ps
module tebf_wb_reader (
   input wire logic clk_sys,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i
);
   import tebf_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero; the address and data lines hold junk, not zeros.
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_sel_o = 4'h0;
      wb_adr_o = 8'hff;
      wb_dat_o = 32'hffffffff;
   end
   // One classic cycle; the request stands until ack is seen at a rising edge.
   // Released address and data lines show the inverse of their last value, so a slave that
   // samples them late cannot pass by luck.
   task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                         output logic [31:0] rdat);
      @(posedge clk_sys);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_sel_o <= 4'hf;
      wb_adr_o <= adr;
      wb_dat_o <= wdat;
      do @(posedge clk_sys); while (wb_ack_i !== 1'b1);
      rdat = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      wb_sel_o <= 4'h0;
      wb_adr_o <= ~adr;
      wb_dat_o <= ~wdat;
   endtask
endmodule

/* File: tb_trigger_event_block_formatter.sv */
// Self-checking testbench for the trigger event block formatter.
`timescale 1ns/100ps
module tb_trigger_event_block_formatter;
   import tebf_pkg::*;
   logic clk_sys, sys_rst, sync_event_flag, trig_valid, trig_ready;
   logic [4:0] slot_geographic_id;
   tebf_trig_t trig_in;
   logic wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat, rd_w;
   int fail_count, total_checks, cycles, words;
   logic [21:0] blk_num; // Expected block number of the block being read.
   logic [47:0] trig_num; // Expected number of the next trigger.
   tebf_src_t row_src [8]; // Table rows: source, bit index, expected type code.
   logic [4:0] row_idx [8];
   logic [7:0] row_tt [8];
   tebf_formatter tebf_formatter_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .slot_geographic_id(slot_geographic_id), .sync_event_flag(sync_event_flag),
      .trig_valid(trig_valid), .trig_ready(trig_ready), .trig_in(trig_in),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
   tebf_wb_reader tebf_wb_reader_i (.clk_sys(clk_sys), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
      .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat),
      .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack));
   ////////////////////////////////////////////////////////////////////////////////
   // 100 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Hang guard: a run of this size needs far fewer than 20000 cycles.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles >= 20000) begin
         fail_count++;
         $display("Timeout after %0d cycles", cycles);
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] unused;
      tebf_wb_reader_i.access(1'b1, adr, d, unused);
   endtask
   // Pops one readout word and compares it.
   task automatic pop(input logic [31:0] exp);
      tebf_wb_reader_i.access(1'b0, TEBF_OFS_DATA, 32'h0, rd_w);
      chk(exp, rd_w);
   endtask
   // Offers one trigger and holds it until the formatter takes it.
   task automatic send_trig(input tebf_src_t s, input logic [4:0] i, input logic [5:0] p,
                            input logic [3:0] d, input logic [7:0] l, input logic [47:0] t);
      @(posedge clk_sys);
      trig_valid <= 1'b1;
      trig_in <= '{src: s, bit_idx: i, panel_in: p, dup_bus: d, local_cnt: l, tstamp: t};
      do @(posedge clk_sys); while (trig_ready !== 1'b1);
      trig_valid <= 1'b0;
   endtask
   task automatic head(input logic [7:0] size, input logic tsf);
      pop({TEBF_IND_BHDR, slot_geographic_id, TEBF_BOARD_TYPE, blk_num[9:0], size});
      pop({15'h7f88, tsf, 8'h20, size});
   endtask
   // Event words in ascending order, each optional word when its format bit is set.
   task automatic evt(input logic [7:0] tt, input logic [5:0] p, input logic [47:0] t,
                      input logic [3:0] fmt, input logic alt, input logic [3:0] d,
                      input logic [7:0] l);
      logic [15:0] n;
      n = 16'h1 + fmt[1] + fmt[2] + fmt[3];
      pop({tt, 8'h01, n});
      pop(trig_num[31:0]);
      if (fmt[1]) pop(t[31:0]);
      if (fmt[2] && alt) pop({d, l, trig_num[35:32], t[47:32]});
      if (fmt[2] && !alt) pop({trig_num[47:32], t[47:32]});
      if (fmt[3]) pop({16'hda56, 10'h000, p});
      words += n + 1;
      trig_num++;
   endtask
   // Trailer, one filler to an even total, the empty-buffer marker, next block number.
   task automatic tail(input logic sst);
      pop({TEBF_IND_BTRL, slot_geographic_id, sync_event_flag, 21'(words)});
      if (words % 2 == 0 && sst) begin
         pop({5'h1f, slot_geographic_id, 22'h0f1110});
      end else if (words % 2 == 0) begin
         pop({5'h1f, slot_geographic_id, blk_num});
      end
      pop({5'h1e, slot_geographic_id, 22'h00bad0});
      tebf_wb_reader_i.access(1'b0, TEBF_OFS_BLKNUM, 32'h0, rd_w);
      chk({10'h000, blk_num + 22'h1}, rd_w);
      blk_num++;
      words = 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, table of trigger types, then the awkward blocks.
   initial begin
      sys_rst = 1'b1;
      sync_event_flag = 1'b0;
      trig_valid = 1'b0;
      trig_in = '0;
      slot_geographic_id = 5'h13;
      fail_count = 0;
      total_checks = 0;
      cycles = 0;
      words = 0;
      blk_num = 22'h1;
      trig_num = 48'h1;
      row_src = '{TEBF_SRC_GTP, TEBF_SRC_GTP, TEBF_SRC_PANEL, TEBF_SRC_PANEL,
                  TEBF_SRC_MULTI, TEBF_SRC_SOFT, TEBF_SRC_RANDOM, TEBF_SRC_FILLER};
      row_idx = '{5'h00, 5'h1f, 5'h00, 5'h1f, 5'h00, 5'h00, 5'h00, 5'h00};
      row_tt = '{8'h01, 8'h20, 8'h21, 8'h40, 8'hfc, 8'hfd, 8'hfe, 8'h00};
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      tebf_wb_reader_i.access(1'b0, TEBF_OFS_BLKSIZE, 32'h0, rd_w);
      chk(32'h1, rd_w);
      tebf_wb_reader_i.access(1'b0, TEBF_OFS_STATUS, 32'h0, rd_w);
      chk(32'h1, rd_w);
      tebf_wb_reader_i.access(1'b0, 8'h3c, 32'h0, rd_w);
      chk(32'h0, rd_w);
      pop({5'h1e, slot_geographic_id, 22'h00bad0});
      $display("Reset test done");
      // One-trigger blocks, plain format, D64 filler after an odd total.
      for (int r = 0; r < 8; r++) begin
         send_trig(row_src[r], row_idx[r], 6'h00, 4'h0, 8'h00, 48'h0);
         head(8'h01, 1'b0);
         evt(row_tt[r], 6'h00, 48'h0, 4'h0, 1'b0, 4'h0, 8'h00);
         tail(1'b0);
      end
      $display("Trigger type table done");
      // Two triggers per block, every optional word, one 2eSST filler, sync flag.
      wr(TEBF_OFS_BLKSIZE, 32'h2);
      wr(TEBF_OFS_FORMAT, 32'he);
      wr(TEBF_OFS_CTRL, 32'h9);
      sync_event_flag <= 1'b1;
      send_trig(TEBF_SRC_GTP, 5'h07, 6'h2a, 4'h3, 8'h11, 48'h1234_89abcdef);
      head(8'h02, 1'b1);
      evt(8'h08, 6'h2a, 48'h1234_89abcdef, 4'he, 1'b0, 4'h3, 8'h11);
      send_trig(TEBF_SRC_PANEL, 5'h02, 6'h3f, 4'h0, 8'h00, 48'h8001_00000004);
      evt(8'h23, 6'h3f, 48'h8001_00000004, 4'he, 1'b0, 4'h0, 8'h00);
      tail(1'b1);
      $display("Full format block done");
      // Master mode and alternate extension word as the third word, even total needs no filler.
      // A zero block size is held at one trigger per block.
      wr(TEBF_OFS_BLKSIZE, 32'h0);
      tebf_wb_reader_i.access(1'b0, TEBF_OFS_BLKSIZE, 32'h0, rd_w);
      chk(32'h1, rd_w);
      wr(TEBF_OFS_FORMAT, 32'h4);
      wr(TEBF_OFS_CTRL, 32'h6);
      sync_event_flag <= 1'b0;
      send_trig(TEBF_SRC_SOFT, 5'h00, 6'h15, 4'ha, 8'h5c, 48'habcd_00000000);
      head(8'h01, 1'b0);
      evt({6'h15, 2'b01}, 6'h15, 48'habcd_00000000, 4'h4, 1'b1, 4'ha, 8'h5c);
      tail(1'b0);
      $display("Master mode block done");
      end_of_test();
   end
endmodule
